// ===== dsbwd_pkg.sv
// Package for the data space bank and window decoder.
// Assumes an 8-bit core data bus with 8-bit data-space addresses.
package dsbwd_pkg;
    // ============================================================
    // Data-space map
    localparam logic [7:0] DS_BANK_LO    = 8'h00;
    localparam logic [7:0] DS_BANK_HI    = 8'h3F;
    localparam logic [7:0] DS_WIN_LO     = 8'h40;
    localparam logic [7:0] DS_WIN_HI     = 8'h7F;
    localparam logic [7:0] DS_RAM_LO     = 8'h80;
    localparam logic [7:0] DS_RAM_HI     = 8'hBF;
    localparam logic [7:0] ADDR_WIN_REG  = 8'hC9;
    localparam logic [7:0] ADDR_BANK_REG = 8'hE8;
    localparam int         PAGE_BITS     = 6;
    localparam int         ROM_AW        = 14;

    // ============================================================
    // Bank select codes
    localparam logic [7:0] SEL_EE0  = 8'h01;
    localparam logic [7:0] SEL_EE1  = 8'h02;
    localparam logic [7:0] SEL_EE2  = 8'h03;
    localparam logic [7:0] SEL_EE3  = 8'h81;
    localparam logic [7:0] SEL_EE4  = 8'h82;
    localparam logic [7:0] SEL_EE5  = 8'h83;
    localparam logic [7:0] SEL_RAM2 = 8'h04;
    localparam logic [7:0] SEL_RAM3 = 8'h08;
    localparam logic [7:0] SEL_DDC0 = 8'h10;
    localparam logic [7:0] SEL_DDC1 = 8'h20;

    // Bank target classes
    typedef enum logic [3:0] {
        TGT_NONE = 4'h1,
        TGT_EE   = 4'h2,
        TGT_XRAM = 4'h4,
        TGT_DDC  = 4'h8
    } dsbwd_tgt_t;

    // Undefined-read filler
    localparam logic [7:0] UNDEF_BYTE = 8'hFF;
endpackage

// ===== dsbwd_bank_decode.sv
// Decodes the bank select byte into a target memory and page.
// Assumes a stored select byte from the same clock domain.
module dsbwd_bank_decode
    import dsbwd_pkg::*;
(
    // Select byte
    input  wire logic [7:0] bankSel,
    // Decoded target
    output dsbwd_tgt_t      tgt,
    output logic [2:0]      page
);
    // ============================================================
    // Code table
    always_comb begin
        tgt  = TGT_NONE;
        page = 3'h0;
        unique case (bankSel)
            SEL_EE0:  begin tgt = TGT_EE;   page = 3'h0; end
            SEL_EE1:  begin tgt = TGT_EE;   page = 3'h1; end
            SEL_EE2:  begin tgt = TGT_EE;   page = 3'h2; end
            SEL_EE3:  begin tgt = TGT_EE;   page = 3'h3; end
            SEL_EE4:  begin tgt = TGT_EE;   page = 3'h4; end
            SEL_EE5:  begin tgt = TGT_EE;   page = 3'h5; end
            SEL_RAM2: begin tgt = TGT_XRAM; page = 3'h0; end
            SEL_RAM3: begin tgt = TGT_XRAM; page = 3'h1; end
            SEL_DDC0: begin tgt = TGT_DDC;  page = 3'h0; end
            SEL_DDC1: begin tgt = TGT_DDC;  page = 3'h1; end
            default:  begin tgt = TGT_NONE; page = 3'h0; end
        endcase
    end
endmodule

// ===== dsbwd_rom_window.sv
// Forms the program ROM byte address for data ROM window reads.
// Assumes the ROM array answers with combinational read data.
module dsbwd_rom_window
    import dsbwd_pkg::*;
(
    // Inputs
    input  wire logic [7:0]        winBase,
    input  wire logic [7:0]        dsAddr,
    // ROM address
    output logic [ROM_AW-1:0]      romAddr
);
    logic [15:0] fullAddr;

    // Window base on top, low six address bits below
    always_comb begin
        fullAddr = {2'b00, winBase, dsAddr[PAGE_BITS-1:0]};
        romAddr  = fullAddr[ROM_AW-1:0];
    end
endmodule

// ===== dsbwd_decoder.sv
// Data space bank and window decoder: maps core data accesses to RAM,
// banked RAM/EEPROM pages and the program ROM window.
// Assumes core read/write strobes last one cycle and arrays answer reads
// combinationally; all signals on sys_clk.
//
// Functional notes
// - Addresses 80h-BFh go straight to the 64-byte data RAM, whatever bank or window.
// - Addresses 00h-3Fh go to a 64-byte bank over extra RAM and all EEPROM, one page at a time.
// - Reads at 40h-7Fh return program ROM bytes through a read-only window.
// - The ROM address is the window base on top of the low six data address bits.
// - The window moves in 64-byte steps, and base zero covers ROM 000h-03Fh.
// - The window base is a write-only byte at C9h, unreadable and cleared to 00h at reset.
// - The bank select is a write-only byte at E8h, cleared to 00h at reset.
// - Bank select bits 5 and 4 each map one display-channel EEPROM page.
// - Bank select bits 3 and 2 each map one extra RAM page.
// - Bank select bits 7, 1 and 0 choose the general EEPROM page.
// - Codes 01h-03h, 81h-83h, 04h, 08h, 10h, 20h select the listed pages.
// - Write-only registers do not support bit set, clear or test.
module dsbwd_decoder
    import dsbwd_pkg::*;
#(
    parameter int RAM_DEPTH = 64,
    parameter int XRAM_DEPTH = 128,
    parameter int EE_DEPTH  = 384,
    parameter int DDC_DEPTH = 128
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    // Core data bus
    input  wire logic [7:0]         coreAddr,
    input  wire logic [7:0]         coreWdata,
    input  wire logic               coreRd,
    input  wire logic               coreWr,
    input  wire logic               coreBitOp,
    output logic [7:0]              coreRdata,
    output logic                    coreHit,
    // Program ROM read port
    output logic [ROM_AW-1:0]       romAddr,
    output logic                    romRd,
    input  wire logic [7:0]         romRdata,
    // General EEPROM array port
    output logic [8:0]              eeAddr,
    output logic                    eeRd,
    output logic                    eeWr,
    output logic [7:0]              eeWdata,
    input  wire logic [7:0]         eeRdata,
    // Display-channel EEPROM array port
    output logic [6:0]              ddcAddr,
    output logic                    ddcRd,
    output logic                    ddcWr,
    output logic [7:0]              ddcWdata,
    input  wire logic [7:0]         ddcRdata
);
    // ============================================================
    // Storage
    logic [7:0] dataRam  [RAM_DEPTH];
    logic [7:0] extraRam [XRAM_DEPTH];

    logic [7:0]  winBase_r;
    logic [7:0]  winBase_nxt;
    logic [7:0]  bankSel_r;
    logic [7:0]  bankSel_nxt;
    logic [7:0]  rdData_r;
    logic [7:0]  rdData_nxt;
    logic        inBank;
    logic        inWin;
    logic        inRam;
    logic        regWr;
    dsbwd_tgt_t  tgt;
    logic [2:0]  page;
    logic [8:0]  pageAddr;

    function automatic logic inRange(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // ============================================================
    // Decoders
    dsbwd_bank_decode u_bank (
        .bankSel (bankSel_r),
        .tgt     (tgt),
        .page    (page)
    );

    dsbwd_rom_window u_win (
        .winBase (winBase_r),
        .dsAddr  (coreAddr),
        .romAddr (romAddr)
    );

    // Region decode
    always_comb begin
        inBank   = inRange(coreAddr, DS_BANK_LO, DS_BANK_HI);
        inWin    = inRange(coreAddr, DS_WIN_LO, DS_WIN_HI);
        inRam    = inRange(coreAddr, DS_RAM_LO, DS_RAM_HI);
        pageAddr = {page, coreAddr[PAGE_BITS-1:0]};
        // Bit instructions are not honoured on write-only registers
        regWr    = coreWr && !coreBitOp;
    end

    // ============================================================
    // Write-only registers
    always_comb begin
        winBase_nxt = winBase_r;
        bankSel_nxt = bankSel_r;
        if (regWr && coreAddr == ADDR_WIN_REG) begin
            winBase_nxt = coreWdata;
        end
        if (regWr && coreAddr == ADDR_BANK_REG) begin
            bankSel_nxt = coreWdata;
        end
    end

    // Reset loads 00h into both registers; software must load them
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            winBase_r <= 8'h00;
            bankSel_r <= 8'h00;
        end else begin
            winBase_r <= winBase_nxt;
            bankSel_r <= bankSel_nxt;
        end
    end

    // ============================================================
    // Array strobes
    always_comb begin
        romRd    = coreRd && inWin;
        eeAddr   = pageAddr;
        eeRd     = coreRd && inBank && tgt == TGT_EE;
        eeWr     = coreWr && inBank && tgt == TGT_EE;
        eeWdata  = coreWdata;
        ddcAddr  = pageAddr[6:0];
        ddcRd    = coreRd && inBank && tgt == TGT_DDC;
        ddcWr    = coreWr && inBank && tgt == TGT_DDC;
        ddcWdata = coreWdata;
    end

    // RAM writes; window area and registers are never written
    always_ff @(posedge sys_clk) begin
        if (coreWr && inRam) begin
            dataRam[coreAddr[PAGE_BITS-1:0]] <= coreWdata;
        end
        if (coreWr && inBank && tgt == TGT_XRAM) begin
            extraRam[pageAddr[6:0]] <= coreWdata;
        end
    end

    // ============================================================
    // Read data mux, registered
    always_comb begin
        rdData_nxt = rdData_r;
        if (coreRd) begin
            rdData_nxt = UNDEF_BYTE;
            if (inRam) begin
                rdData_nxt = dataRam[coreAddr[PAGE_BITS-1:0]];
            end else if (inWin) begin
                rdData_nxt = romRdata;
            end else if (inBank) begin
                unique case (tgt)
                    TGT_EE:   rdData_nxt = eeRdata;
                    TGT_DDC:  rdData_nxt = ddcRdata;
                    TGT_XRAM: rdData_nxt = extraRam[pageAddr[6:0]];
                    TGT_NONE: rdData_nxt = UNDEF_BYTE;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdData_r <= 8'h00;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    // Outputs
    always_comb begin
        coreRdata = rdData_r;
        coreHit   = inBank || inWin || inRam || coreAddr == ADDR_WIN_REG
                    || coreAddr == ADDR_BANK_REG;
    end
endmodule

// ===== dsbwd_checker.sv
// Port checker for the bank and window decoder.
// Assumes a bind onto dsbwd_decoder; one clock domain.
module dsbwd_checker
    import dsbwd_pkg::*;
(
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              resetn,
    // Core side
    input wire logic [7:0]        coreAddr,
    input wire logic [7:0]        coreWdata,
    input wire logic              coreRd,
    input wire logic              coreWr,
    input wire logic              coreBitOp,
    input wire logic [7:0]        coreRdata,
    input wire logic              coreHit,
    // Array side
    input wire logic [ROM_AW-1:0] romAddr,
    input wire logic              romRd,
    input wire logic [7:0]        romRdata,
    input wire logic [6:0]        ddcAddr,
    input wire logic              ddcRd,
    input wire logic              ddcWr,
    input wire logic              eeRd,
    input wire logic              eeWr
);
    // ==========================================================
    // Port relations
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_hit; coreHit == (coreAddr <= DS_RAM_HI || coreAddr == ADDR_WIN_REG
        || coreAddr == ADDR_BANK_REG); endproperty
    a_hit: assert property (p_hit) else $error("coreHit wrong");
    property p_romlo; romAddr[5:0] == coreAddr[5:0]; endproperty
    a_romlo: assert property (p_romlo) else $error("ROM low bits wrong");
    property p_romrd; romRd == (coreRd && coreAddr >= DS_WIN_LO && coreAddr <= DS_WIN_HI);
    endproperty
    a_romrd: assert property (p_romrd) else $error("romRd wrong");
    property p_winwr; coreWr && !coreBitOp && coreAddr == ADDR_WIN_REG
        |=> romAddr[13:6] == $past(coreWdata); endproperty
    a_winwr: assert property (p_winwr) else $error("window base not taken");
    property p_bitop; coreWr && coreBitOp && coreAddr == ADDR_WIN_REG
        |=> romAddr[13:6] == $past(romAddr[13:6]); endproperty
    a_bitop: assert property (p_bitop) else $error("bit op changed window");
    property p_regrd; coreRd && (coreAddr == ADDR_WIN_REG || coreAddr == ADDR_BANK_REG)
        |=> coreRdata == UNDEF_BYTE; endproperty
    a_regrd: assert property (p_regrd) else $error("select register readable");
    property p_romdat; coreRd && coreAddr >= DS_WIN_LO && coreAddr <= DS_WIN_HI
        |=> coreRdata == $past(romRdata); endproperty
    a_romdat: assert property (p_romdat) else $error("window data wrong");
    property p_ddc0; coreWr && !coreBitOp && coreAddr == ADDR_BANK_REG && coreWdata == SEL_DDC0
        ##1 coreRd && coreAddr <= DS_BANK_HI |-> ddcRd && ddcAddr == {1'b0, coreAddr[5:0]};
    endproperty
    a_ddc0: assert property (p_ddc0) else $error("display page 0 not mapped");
    property p_eerd; eeRd |-> coreRd && coreAddr <= DS_BANK_HI && !ddcRd; endproperty
    a_eerd: assert property (p_eerd) else $error("general EEPROM read strobe stray");
    property p_bankwr; eeWr || ddcWr |-> coreWr && coreAddr <= DS_BANK_HI && !(eeWr && ddcWr);
    endproperty
    a_bankwr: assert property (p_bankwr) else $error("EEPROM write strobe stray");
    property p_nopage; coreWr && !coreBitOp && coreAddr == ADDR_BANK_REG && coreWdata == 8'h00
        |=> !(eeRd || eeWr || ddcRd || ddcWr); endproperty
    a_nopage: assert property (p_nopage) else $error("strobe with no page selected");
endmodule

// ===== test_data_space_bank_window_decoder.sv
// Self-checking bench for the bank and window decoder.
// Assumes dsbwd_pkg, the design and dsbwd_checker compiled first.
module test_data_space_bank_window_decoder
    import dsbwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Signals and model state
    logic              sys_clk, resetn, coreRd, coreWr, coreBitOp, coreHit;
    logic              romRd, eeRd, eeWr, ddcRd, ddcWr;
    logic [7:0]        coreAddr, coreWdata, coreRdata, romRdata, eeRdata, eeWdata;
    logic [7:0]        ddcRdata, ddcWdata, mBank, mWin;
    logic [ROM_AW-1:0] romAddr;
    logic [8:0]        eeAddr;
    logic [6:0]        ddcAddr;
    logic [7:0]        eeArr [384];
    logic [7:0]        ddcArr [128];
    logic [7:0]        mem [int];
    logic [7:0]        codes [13] = '{8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83, 8'h04,
                                      8'h08, 8'h10, 8'h20, 8'h00, 8'h80, 8'h00};
    logic [31:0]       seed = 32'h0000_8A6B;
    int                failures = 0;
    int                n_tests = 0;

    dsbwd_decoder i_dsbwd_decoder (.sys_clk, .resetn, .coreAddr, .coreWdata, .coreRd,
        .coreWr, .coreBitOp, .coreRdata, .coreHit, .romAddr, .romRd, .romRdata, .eeAddr,
        .eeRd, .eeWr, .eeWdata, .eeRdata, .ddcAddr, .ddcRd, .ddcWr, .ddcWdata, .ddcRdata);

    // Bench-side arrays answering combinationally
    function automatic logic [7:0] romByte(input logic [13:0] a);
        return a[7:0] ^ {2'h0, a[13:8]};
    endfunction
    assign romRdata = romByte(romAddr);
    assign eeRdata  = eeArr[eeAddr];
    assign ddcRdata = ddcArr[ddcAddr];
    always @(posedge sys_clk) begin
        if (eeWr === 1'b1) eeArr[eeAddr] <= eeWdata;
        if (ddcWr === 1'b1) ddcArr[ddcAddr] <= ddcWdata;
    end

    // Clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #(25 * 2000);
        failures++;
        end_of_test();
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Model location of an address, -1 outside the data RAM and the selected bank page
    function automatic int key(input logic [7:0] a);
        int p;
        if (a >= 8'h80 && a <= 8'hBF) return 32'h100 + a[5:0];
        if (a > 8'h3F) return -1;
        case (mBank)
            8'h01, 8'h02, 8'h03: p = 32'h1C0 + 64 * mBank[1:0];
            8'h81, 8'h82, 8'h83: p = 32'h280 + 64 * mBank[1:0];
            8'h04: p = 32'h400;
            8'h08: p = 32'h440;
            8'h10: p = 32'h500;
            8'h20: p = 32'h540;
            default: return -1;
        endcase
        return p + a[5:0];
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    // One access at a falling edge, result checked one cycle later
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic bo);
        int   k;
        logic [7:0] e;
        logic sk;
        k = key(a);
        e = 8'hFF;
        sk = 1'b0;
        if (a >= 8'h40 && a <= 8'h7F) e = romByte({mWin, a[5:0]});
        else if (k >= 0) begin
            sk = !mem.exists(k);
            if (!sk) e = mem[k];
        end
        // Shadow copies updated before the register write
        if (wr && !(bo && (a == 8'hC9 || a == 8'hE8))) begin
            if (a == 8'hC9) mWin = d;
            else if (a == 8'hE8) mBank = d;
            else if (k >= 0) mem[k] = d;
        end
        coreAddr = a;
        coreWdata = d;
        coreWr = wr;
        coreRd = !wr;
        coreBitOp = bo;
        @(negedge sys_clk);
        if (!wr && !sk) chk("coreRdata", e, coreRdata);
    endtask

    task automatic end_of_test();
        if (failures == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [7:0]  a;
        {resetn, coreRd, coreWr, coreBitOp, coreAddr, coreWdata} = '0;
        {mBank, mWin} = '0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        foreach (codes[i]) begin
            acc(1'b1, 8'hE8, codes[i], 1'b0);
            acc(1'b0, 8'h3F, 8'h00, 1'b0);
            acc(1'b1, 8'h00, xs(), 1'b0);
            acc(1'b1, 8'h3F, xs(), 1'b0);
        end
        foreach (codes[i]) begin
            acc(1'b1, 8'hE8, codes[i], 1'b0);
            acc(1'b0, 8'h00, 8'h00, 1'b0);
            acc(1'b0, 8'h3F, 8'h00, 1'b0);
        end
        foreach (codes[i]) begin
            acc(1'b1, 8'hC9, codes[i] ^ 8'hA5, i[3]);
            acc(1'b0, 8'h40, 8'h00, 1'b0);
            acc(1'b0, 8'h7F, 8'h00, 1'b0);
            acc(1'b0, i[0] ? 8'hC9 : 8'hE8, 8'h00, 1'b0);
        end
        repeat (400) begin
            r = xs();
            a = r[10:8] == 0 ? 8'hE8 : r[10:8] == 1 ? 8'hC9 : r[7:0];
            // Random data never reaches the bank select
            if (r[10:8] != 0 && a == 8'hE8) a = 8'hE9;
            acc(r[11], a, r[10:8] == 0 ? codes[r[31:24] % 13] : r[23:16], r[12] & r[13]);
        end
        coreRd = 1'b0;
        coreWr = 1'b0;
        @(negedge sys_clk);
        end_of_test();
    end
endmodule

bind dsbwd_decoder dsbwd_checker i_dsbwd_checker (.sys_clk, .resetn, .coreAddr,
    .coreWdata, .coreRd, .coreWr, .coreBitOp, .coreRdata, .coreHit, .romAddr, .romRd,
    .romRdata, .ddcAddr, .ddcRd, .ddcWr, .eeRd, .eeWr);
